// *** logic/overclock_watchdog_reset.v ***
// Functional notes
// - Expiry drives a 20 ms reset pulse.
// - Arming loads interval times scale, counts down.
// - Zero while armed: reset and alarm set.
// - Reset pin usable only when strap low.
// - Interval or scale change restarts countdown.
// - Idle after pulse until rewrite or rearm.
// - Arm resets zero; rising edge reloads.
// - Three-bit interval, code zero test mode.
// - Alarm resets zero, set on expiry, clearable.
// - Scale bit: 250 ms or 3 s, reset one.
// - Reset-mode zero recovers, one pulse only.
// - Recovery source: hardware or stored N.
// - Autorecovery resets one; clear allows user writes.
// - Nine-bit recovery N register.
// - Hardware recovery restores boot M, N, O.
// - Auto recovery restores values captured at arm.
// - Manual: user N, hidden captured M.
// - No recovery keeps current dividers.
// - Soft reset bit write emits pulse.
// - Soft pulse length equals expiry pulse.
// - Soft reset bit self-clears as the pulse starts.
// - Low N byte at index 15, resets zero.
// - Only CPU PLL dividers are restored.
// - Software-select frequency uses hardware recovery only.
`timescale 1ns/10ps
`include "wdog_map.vh"

module overclock_watchdog_reset #(
    parameter MW      = 7,
    parameter NW      = 9,
    parameter OW      = 4,
    parameter TICK_DIV = `WDOG_CLK_MHZ * `WDOG_TICK_US
) (
    // Clock and reset.
    input  wire          clock_i,
    input  wire          rst_b_i,
    // Management register byte port.
    input  wire          reg_wr_i,
    input  wire [7:0]    reg_idx_i,
    input  wire [7:0]    reg_wdata_i,
    input  wire          xfer_done_i,
    output reg  [7:0]    reg_rdata_o,
    // Boot straps and power good.
    input  wire          cpu_rail_good_in_n_i,
    input  wire          reset_pin_enable_strap_i,
    input  wire [MW-1:0] boot_m_i,
    input  wire [NW-1:0] boot_n_i,
    input  wire [OW-1:0] boot_o_i,
    input  wire          sw_freq_select_code_i,
    // Current CPU PLL dividers.
    input  wire [MW-1:0] cur_m_i,
    input  wire [NW-1:0] cur_n_i,
    // Restore outputs toward the CPU PLL.
    output reg           restore_o,
    output reg  [MW-1:0] restore_m_o,
    output reg  [NW-1:0] restore_n_o,
    output reg           restore_o_valid_o,
    output reg  [OW-1:0] restore_div_o_o,
    // System reset pin.
    output reg           system_reset_out_n_o
);
    // Counter width; sixteen bits hold the longest interval in ticks.
    localparam CW = 16;

    // Pulse and scale lengths in ticks.
    localparam [CW-1:0] PULSE_TICKS  = (`WDOG_PULSE_MS * 1000) / `WDOG_TICK_US;
    localparam [CW-1:0] SCALE0_TICKS = (`WDOG_SCALE0_MS * 1000) / `WDOG_TICK_US;
    localparam [CW-1:0] SCALE1_TICKS = (`WDOG_SCALE1_MS * 1000) / `WDOG_TICK_US;

    // Sequencer states.
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_COUNT = 2'h1;
    localparam [1:0] ST_PULSE = 2'h2;

    // Register fields; all but the hidden captured recovery M are software-visible.
    reg              arm_bit_ff;
    reg  [2:0]       intv_ff;
    reg              scale_ff;
    reg              rmode_ff;
    reg              rsrc_ff;
    reg              soft_rst_ff;
    reg              auto_ff;
    reg              alarm_ff;
    reg  [NW-1:0]    recov_n_ff;
    reg  [MW-1:0]    recov_m_ff;

    // Values caught once at boot.
    reg              strap_ok_ff;
    reg              booted_ff;
    reg  [MW-1:0]    hw_m_ff;
    reg  [NW-1:0]    hw_n_ff;
    reg  [OW-1:0]    hw_o_ff;

    // Countdown and pulse sequencer state.
    reg  [1:0]       state_ff;
    reg  [CW-1:0]    cnt_ff;
    reg              soft_pend_ff;
    reg              soft_pulse_ff;
    wire             tick;
    reg  [CW-1:0]    nxt_load;

    // Decoded write strobes and sequencer events.
    wire             wr_ctrl;
    wire             wr_auto;
    wire             wr_n_lo;
    wire             wr_n_hi;
    wire             soft_req;
    wire             rearm;
    wire             retime;
    wire             expire;

    // True when this cycle carries a byte write to the wanted index.
    function wr_hit;
        input       wr;
        input [7:0] idx;
        input [7:0] want;
        begin
            wr_hit = wr && (idx == want);
        end
    endfunction

    // Interval code times the selected scale; code zero is the short test mode.
    function [CW-1:0] load_val;
        input [2:0] code;
        input       scale;
        begin
            if (code == 3'h0) begin
                load_val = 16'h0001;
            end else if (scale) begin
                load_val = SCALE1_TICKS * {13'h0, code};
            end else begin
                load_val = SCALE0_TICKS * {13'h0, code};
            end
        end
    endfunction

    wdog_tick_div #(
        .DIV (TICK_DIV)
    ) u_tick (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .tick_o  (tick)
    );

    // Byte write decode; recovery N bytes are refused while autorecovery owns them.
    assign wr_ctrl  = wr_hit(reg_wr_i, reg_idx_i, `WDOG_IDX_CTRL);
    assign wr_auto  = wr_hit(reg_wr_i, reg_idx_i, `WDOG_IDX_AUTO);
    assign wr_n_lo  = wr_hit(reg_wr_i, reg_idx_i, `WDOG_IDX_RECOV_N_LO) && !auto_ff;
    assign wr_n_hi  = wr_hit(reg_wr_i, reg_idx_i, `WDOG_IDX_RECOV_N_HI) && !auto_ff;
    assign soft_req = wr_ctrl && reg_wdata_i[`WDOG_CTRL_SOFTRST];

    // Arming edge, interval change and expiry events.
    assign rearm   = wr_ctrl && reg_wdata_i[`WDOG_CTRL_ARM] && !arm_bit_ff;
    assign retime  = wr_ctrl && arm_bit_ff && reg_wdata_i[`WDOG_CTRL_ARM] &&
                     ((reg_wdata_i[`WDOG_CTRL_INTV_HI:`WDOG_CTRL_INTV_LO] != intv_ff) ||
                      (reg_wdata_i[`WDOG_CTRL_SCALE] != scale_ff));
    assign expire  = (state_ff == ST_COUNT) && tick && (cnt_ff <= 16'h0001) &&
                     arm_bit_ff;

    always @* begin
        nxt_load = load_val(reg_wdata_i[`WDOG_CTRL_INTV_HI:`WDOG_CTRL_INTV_LO],
                            reg_wdata_i[`WDOG_CTRL_SCALE]);
    end

    // Boot straps are caught once, at the first low level of power good.
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            booted_ff   <= 1'b0;
            strap_ok_ff <= 1'b0;
            hw_m_ff     <= {MW{1'b0}};
            hw_n_ff     <= {NW{1'b0}};
            hw_o_ff     <= {OW{1'b0}};
        end else if (!booted_ff && !cpu_rail_good_in_n_i) begin
            booted_ff   <= 1'b1;
            strap_ok_ff <= !reset_pin_enable_strap_i;
            hw_m_ff     <= boot_m_i;
            hw_n_ff     <= boot_n_i;
            hw_o_ff     <= boot_o_i;
        end
    end

    // Register writes; hardware events win over software clears.
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            arm_bit_ff  <= 1'b0;
            intv_ff     <= `WDOG_RST_INTV;
            scale_ff    <= `WDOG_RST_SCALE;
            rmode_ff    <= 1'b0;
            rsrc_ff     <= 1'b0;
            soft_rst_ff <= 1'b0;
            auto_ff     <= `WDOG_RST_AUTO;
            alarm_ff    <= 1'b0;
            recov_n_ff  <= `WDOG_RST_RECOV_N;
            recov_m_ff  <= {MW{1'b0}};
        end else begin
            if (wr_ctrl) begin
                arm_bit_ff  <= reg_wdata_i[`WDOG_CTRL_ARM];
                intv_ff     <= reg_wdata_i[`WDOG_CTRL_INTV_HI:`WDOG_CTRL_INTV_LO];
                scale_ff    <= reg_wdata_i[`WDOG_CTRL_SCALE];
                rmode_ff    <= reg_wdata_i[`WDOG_CTRL_RMODE];
                rsrc_ff     <= reg_wdata_i[`WDOG_CTRL_RSRC];
                soft_rst_ff <= reg_wdata_i[`WDOG_CTRL_SOFTRST] | soft_rst_ff;
            end else if (soft_pulse_ff) begin
                soft_rst_ff <= 1'b0;
            end
            if (wr_auto) begin
                auto_ff <= reg_wdata_i[`WDOG_AUTO_BIT];
            end
            // Expiry wins over a clear written in the same cycle.
            if (expire) begin
                alarm_ff <= 1'b1;
            end else if (wr_auto && reg_wdata_i[`WDOG_ALARM_BIT]) begin
                alarm_ff <= 1'b0;
            end
            // Arming captures the current M, and the current N when autorecovery is set, for later restore.
            if (rearm) begin
                recov_m_ff <= cur_m_i;
                if (auto_ff) begin
                    recov_n_ff <= cur_n_i;
                end
            end else if (wr_n_lo) begin
                recov_n_ff[7:0] <= reg_wdata_i;
            end else if (wr_n_hi) begin
                recov_n_ff[NW-1:8] <= reg_wdata_i[NW-9:0];
            end
        end
    end

    // Countdown and pulse sequencer.
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_ff      <= ST_IDLE;
            cnt_ff        <= {CW{1'b0}};
            soft_pend_ff  <= 1'b0;
            soft_pulse_ff <= 1'b0;
        end else begin
            soft_pulse_ff <= 1'b0;
            if (soft_req) begin
                soft_pend_ff <= 1'b1;
            end
            case (state_ff)
                ST_IDLE: begin
                    // A pending soft request at the end of its transfer wins over arming.
                    if (soft_pend_ff && xfer_done_i) begin
                        soft_pend_ff <= 1'b0;
                        soft_pulse_ff <= 1'b1;
                        state_ff     <= ST_PULSE;
                        cnt_ff       <= PULSE_TICKS;
                    end else if (rearm || retime) begin
                        state_ff <= ST_COUNT;
                        cnt_ff   <= nxt_load;
                    end
                end
                ST_COUNT: begin
                    // Disarming stops the count; a new interval restarts it.
                    if (wr_ctrl && !reg_wdata_i[`WDOG_CTRL_ARM]) begin
                        state_ff <= ST_IDLE;
                    end else if (retime) begin
                        cnt_ff <= nxt_load;
                    end else if (soft_pend_ff && xfer_done_i) begin
                        soft_pend_ff  <= 1'b0;
                        soft_pulse_ff <= 1'b1;
                        state_ff      <= ST_PULSE;
                        cnt_ff        <= PULSE_TICKS;
                    end else if (expire) begin
                        state_ff <= ST_PULSE;
                        cnt_ff   <= PULSE_TICKS;
                    end else if (tick) begin
                        cnt_ff <= cnt_ff - 16'h0001;
                    end
                end
                ST_PULSE: begin
                    // The pulse runs its full length whatever is written meanwhile.
                    if (tick) begin
                        if (cnt_ff <= 16'h0001) begin
                            state_ff <= ST_IDLE;
                        end else begin
                            cnt_ff <= cnt_ff - 16'h0001;
                        end
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // Divider restore on expiry, CPU PLL only.
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            restore_o         <= 1'b0;
            restore_m_o       <= {MW{1'b0}};
            restore_n_o       <= {NW{1'b0}};
            restore_o_valid_o <= 1'b0;
            restore_div_o_o   <= {OW{1'b0}};
        end else begin
            restore_o <= expire && !rmode_ff;
            if (expire && !rmode_ff) begin
                if (!rsrc_ff || sw_freq_select_code_i) begin
                    restore_m_o       <= hw_m_ff;
                    restore_n_o       <= hw_n_ff;
                    restore_div_o_o   <= hw_o_ff;
                    restore_o_valid_o <= 1'b1;
                end else begin
                    // Stored values carry no output divider, so its valid flag drops.
                    restore_m_o       <= recov_m_ff;
                    restore_n_o       <= recov_n_ff;
                    restore_o_valid_o <= 1'b0;
                end
            end
        end
    end

    // Reset pin is low only during a pulse and when the strap allowed it.
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            system_reset_out_n_o <= 1'b1;
        end else begin
            system_reset_out_n_o <= !((state_ff == ST_PULSE) && strap_ok_ff);
        end
    end

    // Register readback.
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            case (reg_idx_i)
                `WDOG_IDX_CTRL:       reg_rdata_o <= {soft_rst_ff, rsrc_ff, rmode_ff,
                                                      scale_ff, intv_ff, arm_bit_ff};
                `WDOG_IDX_RECOV_N_LO: reg_rdata_o <= recov_n_ff[7:0];
                `WDOG_IDX_AUTO:       reg_rdata_o <= {6'h00, alarm_ff, auto_ff};
                `WDOG_IDX_RECOV_N_HI: reg_rdata_o <= {{(16-NW){1'b0}}, recov_n_ff[NW-1:8]};
                default:              reg_rdata_o <= 8'h00;
            endcase
        end
    end
endmodule

// *** logic/wdog_map.vh ***
`ifndef WDOG_MAP_VH
`define WDOG_MAP_VH

// Register byte indices on the management bus.
`define WDOG_IDX_CTRL        8'h0E
`define WDOG_IDX_RECOV_N_LO  8'h0F
`define WDOG_IDX_AUTO        8'h10
`define WDOG_IDX_RECOV_N_HI  8'h11

// Control byte field positions.
`define WDOG_CTRL_ARM        0
`define WDOG_CTRL_INTV_LO    1
`define WDOG_CTRL_INTV_HI    3
`define WDOG_CTRL_SCALE      4
`define WDOG_CTRL_RMODE      5
`define WDOG_CTRL_RSRC       6
`define WDOG_CTRL_SOFTRST    7

// Status byte field positions.
`define WDOG_AUTO_BIT        0
`define WDOG_ALARM_BIT       1

// Reset values.
`define WDOG_RST_INTV        3'h0
`define WDOG_RST_SCALE       1'h1
`define WDOG_RST_AUTO        1'h1
`define WDOG_RST_RECOV_N     9'h000

// Timing figures.
`define WDOG_CLK_MHZ         100
`define WDOG_TICK_US         1000
`define WDOG_PULSE_MS        20
`define WDOG_SCALE0_MS       250
`define WDOG_SCALE1_MS       3000

`endif

// *** logic/wdog_tick_div.v ***
`timescale 1ns/10ps
// Divides the reference clock into a one-cycle tick enable.
module wdog_tick_div #(
    parameter DIV = 100000
) (
    // Clock and reset.
    input  wire        clock_i,
    input  wire        rst_b_i,
    // Tick output.
    output reg         tick_o
);
    reg  [31:0] cnt_ff;

    // Free-running counter emits one pulse every DIV cycles.
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_ff <= 32'h0;
            tick_o <= 1'b0;
        end else if (cnt_ff == DIV - 1) begin
            cnt_ff <= 32'h0;
            tick_o <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 32'h1;
            tick_o <= 1'b0;
        end
    end
endmodule

// *** testbench/overclock_watchdog_reset_asserts.sv ***
`timescale 1ns/10ps
`include "wdog_map.vh"
// Watches the reset pin, the restore port and the control readback at the top-level ports.
module overclock_watchdog_reset_asserts #(
    parameter MW       = 7,
    parameter NW       = 9,
    parameter OW       = 4,
    parameter TICK_DIV = 10
) (
    // Clock and reset.
    input wire logic          clock_i,
    input wire logic          rst_b_i,
    // Register port.
    input wire logic          reg_wr_i,
    input wire logic [7:0]    reg_idx_i,
    input wire logic [7:0]    reg_wdata_i,
    input wire logic          xfer_done_i,
    input wire logic [7:0]    reg_rdata_o,
    // Straps and boot dividers.
    input wire logic          reset_pin_enable_strap_i,
    input wire logic [MW-1:0] boot_m_i,
    input wire logic [NW-1:0] boot_n_i,
    input wire logic [OW-1:0] boot_o_i,
    input wire logic          sw_freq_select_code_i,
    // Restore port and reset pin.
    input wire logic          restore_o,
    input wire logic [MW-1:0] restore_m_o,
    input wire logic [NW-1:0] restore_n_o,
    input wire logic          restore_o_valid_o,
    input wire logic [OW-1:0] restore_div_o_o,
    input wire logic          system_reset_out_n_o
);
    logic [15:0] low_cnt_ff;
    logic [7:0]  ctrl_ff;
    logic        soft_ff;

    // Mirrors the written control byte, a pending soft request and the length of a low stretch.
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            low_cnt_ff <= 16'h0000;
            ctrl_ff    <= 8'h10;
            soft_ff    <= 1'b0;
        end else begin
            low_cnt_ff <= system_reset_out_n_o ? 16'h0000 : low_cnt_ff + 16'h0001;
            if (reg_wr_i && reg_idx_i == `WDOG_IDX_CTRL)
                ctrl_ff <= reg_wdata_i;
            if (reg_wr_i && reg_idx_i == `WDOG_IDX_CTRL && reg_wdata_i[7])
                soft_ff <= 1'b1;
            else if (!system_reset_out_n_o)
                soft_ff <= 1'b0;
        end
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_b_i);

    // A finished transaction that carried the soft reset bit, and the pin being driven.
    sequence s_soft_req;
        xfer_done_i && soft_ff;
    endsequence
    sequence s_pin_low;
        !system_reset_out_n_o;
    endsequence

    a_strap_gate: assert property (s_pin_low |-> !reset_pin_enable_strap_i)
        else $error("reset pin driven while the strap disables it");
    a_pulse_width: assert property ($rose(system_reset_out_n_o) |->
        low_cnt_ff >= 19 * TICK_DIV && low_cnt_ff <= 21 * TICK_DIV + 2)
        else $error("reset pulse length off");
    a_restore_single: assert property (restore_o |=> !restore_o)
        else $error("restore strobe longer than one cycle");
    a_soft_start: assert property (s_soft_req |-> ##[1:12] s_pin_low)
        else $error("soft reset pulse did not start");
    a_softbit_clear: assert property (low_cnt_ff > 16'h0004 &&
        $past(reg_idx_i) == `WDOG_IDX_CTRL |-> !reg_rdata_o[`WDOG_CTRL_SOFTRST])
        else $error("soft reset bit still set during pulse");
    a_no_spurious: assert property ($fell(system_reset_out_n_o) |-> ctrl_ff[0] || soft_ff)
        else $error("reset pulse without arming or soft request");
    a_restore_mode: assert property (restore_o |-> ctrl_ff[0] && !ctrl_ff[5])
        else $error("restore issued in pulse-only mode or while disarmed");
    a_hw_restore: assert property (restore_o && (!ctrl_ff[6] || sw_freq_select_code_i) |->
        restore_m_o == boot_m_i && restore_n_o == boot_n_i && restore_o_valid_o
        && restore_div_o_o == boot_o_i)
        else $error("hardware restore values differ from boot dividers");
endmodule

bind overclock_watchdog_reset overclock_watchdog_reset_asserts #(
    .MW(MW), .NW(NW), .OW(OW), .TICK_DIV(TICK_DIV)
) asserts_inst (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i), .reg_idx_i(reg_idx_i),
    .reg_wdata_i(reg_wdata_i), .xfer_done_i(xfer_done_i), .reg_rdata_o(reg_rdata_o),
    .reset_pin_enable_strap_i(reset_pin_enable_strap_i), .boot_m_i(boot_m_i),
    .boot_n_i(boot_n_i), .boot_o_i(boot_o_i), .sw_freq_select_code_i(sw_freq_select_code_i),
    .restore_o(restore_o), .restore_m_o(restore_m_o), .restore_n_o(restore_n_o),
    .restore_o_valid_o(restore_o_valid_o), .restore_div_o_o(restore_div_o_o),
    .system_reset_out_n_o(system_reset_out_n_o)
);

// *** testbench/board_pll_model.sv ***
`timescale 1ns/10ps
// Board straps, power good and the CPU PLL that takes restored dividers.
module board_pll_model #(
    parameter MW     = 7,
    parameter NW     = 9,
    parameter OW     = 4,
    parameter BOOT_M = 7'h15,
    parameter BOOT_N = 9'h0C8,
    parameter BOOT_O = 4'h3
) (
    // Clock and reset.
    input  wire          clock_i,
    input  wire          rst_b_i,
    // Restore request.
    input  wire          restore_i,
    input  wire [MW-1:0] restore_m_i,
    input  wire [NW-1:0] restore_n_i,
    // Test preset of the current dividers.
    input  wire          preset_i,
    input  wire [MW-1:0] preset_m_i,
    input  wire [NW-1:0] preset_n_i,
    // Straps and dividers.
    output reg           cpu_rail_good_in_n_o,
    output wire          reset_pin_enable_strap_o,
    output wire [MW-1:0] boot_m_o,
    output wire [NW-1:0] boot_n_o,
    output wire [OW-1:0] boot_o_o,
    output reg  [MW-1:0] cur_m_o,
    output reg  [NW-1:0] cur_n_o
);
    // Strap tied low so the reset pin is usable; boot dividers are fixed.
    assign reset_pin_enable_strap_o = 1'b0;
    assign boot_m_o = BOOT_M;
    assign boot_n_o = BOOT_N;
    assign boot_o_o = BOOT_O;

    // Power good falls once and stays; the PLL loads dividers on each restore strobe.
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cpu_rail_good_in_n_o <= 1'b1;
            cur_m_o              <= BOOT_M;
            cur_n_o              <= BOOT_N;
        end else begin
            cpu_rail_good_in_n_o <= 1'b0;
            if (restore_i) begin
                cur_m_o <= restore_m_i;
                cur_n_o <= restore_n_i;
            end else if (preset_i) begin
                cur_m_o <= preset_m_i;
                cur_n_o <= preset_n_i;
            end
        end
    end
endmodule

// *** testbench/overclock_watchdog_reset_bench.sv ***
`timescale 1ns/10ps
`include "wdog_map.vh"
module overclock_watchdog_reset_bench;
    localparam TICK = 10;
    reg          clock_i     = 1'b0;
    reg          rst_b_i     = 1'b0;
    reg          reg_wr_i    = 1'b0;
    reg  [7:0]   reg_idx_i   = 8'h00;
    reg  [7:0]   reg_wdata_i = 8'h00;
    reg          xfer_done_i = 1'b0;
    reg          preset      = 1'b0;
    reg  [6:0]   pre_m       = 7'h00;
    reg  [8:0]   pre_n       = 9'h000;
    reg          sw_sel      = 1'b0;
    wire [7:0]   rdata;
    wire         rail_n, strap, rest, rest_ov, pin_n;
    wire [6:0]   boot_m, cur_m, rest_m;
    wire [8:0]   boot_n, cur_n, rest_n;
    wire [3:0]   boot_o, rest_div;
    integer      errors      = 0;
    integer      n_checks    = 0;
    integer      cycles      = 0;
    integer      n;

    // The bench keeps the software frequency select low except for one hardware-restore run.
    overclock_watchdog_reset #(.TICK_DIV(TICK)) overclock_watchdog_reset_inst (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i), .reg_idx_i(reg_idx_i),
        .reg_wdata_i(reg_wdata_i), .xfer_done_i(xfer_done_i), .reg_rdata_o(rdata),
        .cpu_rail_good_in_n_i(rail_n), .reset_pin_enable_strap_i(strap), .boot_m_i(boot_m),
        .boot_n_i(boot_n), .boot_o_i(boot_o), .sw_freq_select_code_i(sw_sel),
        .cur_m_i(cur_m), .cur_n_i(cur_n), .restore_o(rest), .restore_m_o(rest_m),
        .restore_n_o(rest_n), .restore_o_valid_o(rest_ov), .restore_div_o_o(rest_div),
        .system_reset_out_n_o(pin_n));
    board_pll_model board_pll_model_inst (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .restore_i(rest), .restore_m_i(rest_m),
        .restore_n_i(rest_n), .preset_i(preset), .preset_m_i(pre_m), .preset_n_i(pre_n),
        .cpu_rail_good_in_n_o(rail_n), .reset_pin_enable_strap_o(strap),
        .boot_m_o(boot_m), .boot_n_o(boot_n), .boot_o_o(boot_o), .cur_m_o(cur_m),
        .cur_n_o(cur_n));

    // Clock and a cycle ceiling that cuts a hang short.
    always #5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cycles = cycles + 1;
        if (cycles == 40000) begin
            errors = errors + 1;
            final_report;
        end
    end

    task final_report;
        begin
            if (errors == 0 && n_checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    task check(input [15:0] got, input [15:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("MISMATCH %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task in_range(input integer v, input integer lo, input integer hi);
        begin
            n_checks = n_checks + 1;
            if (v < lo || v > hi) begin
                errors = errors + 1;
                $display("MISMATCH %0t count %0d outside %0d..%0d", $time, v, lo, hi);
            end
        end
    endtask

    task wr(input [7:0] idx, input [7:0] data);
        begin
            @(posedge clock_i);
            #1;
            reg_wr_i = 1'b1;
            reg_idx_i = idx;
            reg_wdata_i = data;
            @(posedge clock_i);
            #1;
            reg_wr_i = 1'b0;
        end
    endtask

    task rd(input [7:0] idx, input [7:0] exp);
        begin
            @(posedge clock_i);
            #1;
            reg_idx_i = idx;
            @(posedge clock_i);
            #1;
            check(rdata, exp);
        end
    endtask

    // Makes the board PLL take new current dividers for one cycle.
    task set_cur(input [6:0] m, input [8:0] nv);
        begin
            @(posedge clock_i);
            #1;
            preset = 1'b1;
            pre_m = m;
            pre_n = nv;
            @(posedge clock_i);
            #1;
            preset = 1'b0;
        end
    endtask

    // Counts cycles until the pin reaches a level, giving up after 4000.
    task wait_pin(input lvl, output integer cnt);
        begin
            cnt = 0;
            while (pin_n !== lvl && cnt < 4000) begin
                @(posedge clock_i);
                #1;
                cnt = cnt + 1;
            end
        end
    endtask

    // Arms with a longer interval, shortens it mid-count, then lets the PLL drift and expire.
    task run_wd(input [7:0] ctrl);
        begin
            wr(`WDOG_IDX_CTRL, 8'h00);
            wr(`WDOG_IDX_CTRL, ctrl | 8'h04);
            repeat (1000) @(posedge clock_i);
            wr(`WDOG_IDX_CTRL, ctrl);
            set_cur(7'h44, 9'h088);
            wait_pin(1'b0, n);
            in_range(n, 250 * TICK - 20, 250 * TICK + 30);
            wait_pin(1'b1, n);
            in_range(n, 19 * TICK - 2, 21 * TICK + 2);
        end
    endtask

    // Reset, register defaults, then every recovery mode and the soft reset.
    initial begin
        repeat (4) @(posedge clock_i);
        #1;
        rst_b_i = 1'b1;
        rd(`WDOG_IDX_CTRL, 8'h10);
        rd(`WDOG_IDX_RECOV_N_LO, 8'h00);
        rd(`WDOG_IDX_AUTO, 8'h01);
        rd(`WDOG_IDX_RECOV_N_HI, 8'h00);
        wr(`WDOG_IDX_RECOV_N_LO, 8'hA5);
        rd(`WDOG_IDX_RECOV_N_LO, 8'h00);
        run_wd(8'h03);
        check({cur_m, cur_n}, {7'h15, 9'h0C8});
        rd(`WDOG_IDX_AUTO, 8'h03);
        wr(`WDOG_IDX_AUTO, 8'h03);
        rd(`WDOG_IDX_AUTO, 8'h01);
        wait_pin(1'b0, n);
        check(n, 4000);
        set_cur(7'h2A, 9'h155);
        run_wd(8'h43);
        check({cur_m, cur_n}, {7'h2A, 9'h155});
        wr(`WDOG_IDX_AUTO, 8'h00);
        wr(`WDOG_IDX_RECOV_N_LO, 8'h3C);
        wr(`WDOG_IDX_RECOV_N_HI, 8'h01);
        rd(`WDOG_IDX_RECOV_N_LO, 8'h3C);
        set_cur(7'h33, cur_n);
        run_wd(8'h43);
        check({cur_m, cur_n}, {7'h33, 9'h13C});
        run_wd(8'h23);
        check({cur_m, cur_n}, {7'h44, 9'h088});
        sw_sel = 1'b1;
        run_wd(8'h43);
        check({cur_m, cur_n}, {7'h15, 9'h0C8});
        sw_sel = 1'b0;
        wr(`WDOG_IDX_CTRL, 8'h80);
        check(pin_n, 1'b1);
        @(posedge clock_i);
        #1;
        xfer_done_i = 1'b1;
        @(posedge clock_i);
        #1;
        xfer_done_i = 1'b0;
        wait_pin(1'b0, n);
        in_range(n, 0, 12);
        rd(`WDOG_IDX_CTRL, 8'h00);
        wait_pin(1'b1, n);
        in_range(n, 19 * TICK - 6, 21 * TICK + 2);
        final_report;
    end
endmodule
